// ===== logic/mcg_core.sv
// math coprocessor on the host i/o bus: port decode, sequencer,
// busy hold latch and interrupt request 13
// assumes one-cycle io_wr/io_rd strobes synchronous to core_clk
`timescale 1ns/10ps
`include "mcg_defines.svh"
module mcg_core
  import mcg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] io_addr, // host i/o address
  input wire logic io_wr, // one-cycle write strobe
  input wire logic io_rd, // one-cycle read strobe
  input wire logic io_byte, // write is an 8-bit cycle
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  output logic busy, // seen by host wait logic
  output logic error,
  output logic irq13
);
  localparam int unsigned ExecCyc = `MCG_EXEC_CYC;

  mcg_core_s q, d; // all core state
  mcg_word_t rd_a, rd_b; // operand reads
  logic wr_en; // register write
  logic [2:0] wr_idx;
  mcg_word_t wr_data;
  logic [2:0] ia, ib; // operand indices
  logic [5:0] det; // detected exceptions
  logic det_v;
  logic exc_clr;
  logic [5:0] flags;
  logic [64:0] sum, diff; // sign-extended for overflow
  logic signed [127:0] prod;
  logic signed [63:0] quot, rmd, dvsr;

  // command fields
  mcg_op_e op;
  mcg_fmt_e fmt;
  logic [2:0] idx;
  logic stk; // stack use, else fixed set
  assign op = mcg_op_e'(q.cmd[2:0]);
  assign fmt = mcg_fmt_e'(q.cmd[5:3]);
  assign idx = q.cmd[8:6];
  assign stk = !q.cmd[`MCG_CMD_FIX];

  // port decode; no memory cycles here, host fetches everything
  wire logic exec_busy = q.st != MCG_S_IDLE;
  // no host mode input exists, so every mode decodes alike
  wire logic wr_cmd = io_wr && io_addr == `MCG_PORT_CMD;
  wire logic wr_opnd = io_wr && io_addr == `MCG_PORT_OPND;
  wire logic wr_ctrl = io_wr && io_addr == `MCG_PORT_CTRL;
  wire logic clr_wr = io_wr && io_byte && io_addr == `MCG_PORT_CLR
                      && io_wdata[7:0] == 8'h00;
  wire logic err_rise = error && !q.err_prev;
  wire logic acc = wr_cmd && !exec_busy;

  // sign-extend a 64-bit integer into a data register
  function automatic mcg_word_t sext64(input logic [63:0] v);
    sext64 = {{16{v[63]}}, v};
  endfunction

  // operand word to register image; reals and bcd kept as stored
  function automatic mcg_word_t conv(input mcg_fmt_e f, input mcg_word_t v);
    case (f)
      MCG_F_I16: conv = sext64({{48{v[15]}}, v[15:0]});
      MCG_F_I32: conv = sext64({{32{v[31]}}, v[31:0]});
      MCG_F_I64: conv = sext64(v[63:0]);
      default: conv = v; // bcd and three real widths
    endcase
  endfunction

  // zero exponent with nonzero fraction marks a denormal
  function automatic logic denorm(input mcg_fmt_e f, input mcg_word_t v);
    case (f)
      MCG_F_R24: denorm = v[30:23] == 8'h00 && v[22:0] != 23'h00_0000;
      MCG_F_R53: denorm = v[62:52] == 11'h000 && v[51:0] != 52'h0_0000_0000_0000;
      MCG_F_R64: denorm = v[78:64] == 15'h0000 && v[63:0] != 64'h0;
      default: denorm = 1'b0;
    endcase
  endfunction

  // operand selection: stack uses top two, fixed uses idx pair
  assign ia = stk ? q.top : idx;
  assign ib = stk ? q.top + 3'h1 : idx + 3'h1;

  // integer datapath on the low 64 bits
  assign sum = {rd_a[63], rd_a[63:0]} + {rd_b[63], rd_b[63:0]};
  assign diff = {rd_a[63], rd_a[63:0]} - {rd_b[63], rd_b[63:0]};
  assign prod = $signed(rd_a[63:0]) * $signed(rd_b[63:0]);
  // dummy divisor avoids a divide by zero in the datapath
  assign dvsr = rd_b[63:0] == 64'h0 ? 64'sh1 : $signed(rd_b[63:0]);
  assign quot = $signed(rd_a[63:0]) / dvsr;
  assign rmd = $signed(rd_a[63:0]) % dvsr;

  // next-state logic
  always_comb begin
    d = q;
    wr_en = 1'b0;
    wr_idx = ia;
    wr_data = rd_a;
    det = '0;
    det_v = 1'b0;
    exc_clr = 1'b0;
    d.err_prev = error;
    // operand and control ports; refused while executing
    if (wr_opnd && !exec_busy) begin
      d.opnd = {q.opnd[63:0], io_wdata}; // last word is lowest
    end
    if (wr_ctrl && !exec_busy) begin
      d.ctrl = io_wdata;
    end
    // reads: status, result words high first, control
    if (io_rd) begin
      case (io_addr)
        `MCG_PORT_CMD: d.rdata = {busy, q.hold, q.top, q.depth, error, flags};
        `MCG_PORT_OPND: begin
          d.rdata = q.res[79:64];
          d.res = {q.res[63:0], 16'h0000};
        end
        `MCG_PORT_CTRL: d.rdata = q.ctrl;
        default: d.rdata = 16'h0000; // unmapped
      endcase
    end
    // sequencer
    case (q.st)
      MCG_S_IDLE: begin
        if (acc) begin
          d.cmd = io_wdata;
          d.cnt = 4'(ExecCyc - 2);
          d.st = MCG_S_EXEC;
        end
      end
      MCG_S_EXEC: begin
        if (q.cnt == 4'h0) begin
          d.st = MCG_S_DONE;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      MCG_S_DONE: begin
        d.st = MCG_S_IDLE;
        det_v = 1'b1;
        case (op)
          MCG_OP_LOAD: begin
            if (stk && q.depth == `MCG_DEPTH_MAX) begin
              det[`MCG_EX_IE] = 1'b1;
            end else begin
              wr_en = 1'b1;
              wr_idx = stk ? q.top - 3'h1 : idx;
              wr_data = conv(fmt, q.opnd);
              det[`MCG_EX_DE] = denorm(fmt, q.opnd);
              if (stk) begin
                d.top = q.top - 3'h1;
                d.depth = q.depth + 4'h1;
              end
            end
          end
          MCG_OP_STORE: begin
            if (stk && q.depth == 4'h0) begin
              det[`MCG_EX_IE] = 1'b1;
            end else begin
              d.res = rd_a;
              if (stk) begin
                d.top = q.top + 3'h1;
                d.depth = q.depth - 4'h1;
              end
            end
          end
          MCG_OP_ADD, MCG_OP_SUB, MCG_OP_MUL, MCG_OP_DIV: begin
            if (stk && q.depth < 4'h2) begin
              det[`MCG_EX_IE] = 1'b1;
            end else begin
              wr_en = 1'b1;
              wr_idx = stk ? ib : idx;
              case (op)
                MCG_OP_ADD: begin
                  wr_data = sext64(sum[63:0]);
                  det[`MCG_EX_OE] = sum[64] ^ sum[63];
                end
                MCG_OP_SUB: begin
                  wr_data = sext64(diff[63:0]);
                  det[`MCG_EX_UE] = diff[64] ^ diff[63];
                end
                MCG_OP_MUL: begin
                  wr_data = sext64(prod[63:0]);
                  det[`MCG_EX_OE] = prod[127:63] != {65{prod[63]}};
                end
                default: begin
                  wr_data = sext64(quot);
                  det[`MCG_EX_ZE] = rd_b[63:0] == 64'h0;
                  det[`MCG_EX_PE] = rd_b[63:0] != 64'h0 && rmd != 64'sh0;
                end
              endcase
              if (stk) begin // pop: result lands in new top
                d.top = q.top + 3'h1;
                d.depth = q.depth - 4'h1;
              end
            end
          end
          MCG_OP_CHS: begin
            if (stk && q.depth == 4'h0) begin
              det[`MCG_EX_IE] = 1'b1;
            end else begin
              wr_en = 1'b1;
              wr_data = {~rd_a[79], rd_a[78:0]};
            end
          end
          default: exc_clr = 1'b1; // flag clear
        endcase
      end
      default: d.st = MCG_S_IDLE;
    endcase
    // hold latch and irq: error edge sets, zero byte clears
    if (clr_wr) begin
      d.hold = 1'b0;
      d.irq = 1'b0;
    end
    if (err_rise) begin
      d.hold = 1'b1;
      d.irq = 1'b1;
    end
  end

  // register the copy; reset drops hold and irq so host never stalls
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '{st: MCG_S_IDLE, ctrl: `MCG_CTRL_RST, default: '0};
    end else begin
      q <= d;
    end
  end

  // outputs; busy is handshake so it may be combined
  assign busy = exec_busy || q.hold;
  assign irq13 = q.irq;
  assign io_rdata = q.rdata;

  mcg_regs u_regs (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .rd_a_idx(ia),
    .rd_b_idx(ib),
    .rd_a(rd_a),
    .rd_b(rd_b)
  );

  mcg_exc u_exc (
    .core_clk(core_clk),
    .rst(rst),
    .det(det),
    .det_v(det_v),
    .clr(exc_clr),
    .mask(q.ctrl[5:0]),
    .flags(flags),
    .error(error)
  );

  // execution spans exactly the timed count
  sequence s_exec;
    exec_busy [*8] ##1 !exec_busy;
  endsequence
  exec_span_a: assert property (@(posedge core_clk) disable iff (rst)
    acc |=> s_exec) else $error("busy length wrong");
  cmd_refused_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_cmd && exec_busy |=> $stable(q.cmd)) else $error("command taken while busy");
  // hold and request follow the error edge, not its level
  err_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    err_rise |=> irq13 && busy) else $error("error did not raise irq");
  irq_stays_a: assert property (@(posedge core_clk) disable iff (rst)
    irq13 && !clr_wr |=> irq13 && busy) else $error("irq dropped without clear");
  clear_port_a: assert property (@(posedge core_clk) disable iff (rst)
    clr_wr && !err_rise |=> !irq13 && !q.hold) else $error("clear write ignored");
  reset_clear_a: assert property (@(posedge core_clk)
    $fell(rst) |-> !irq13 && !busy) else $error("hold or irq survives reset");
  stack_pop_a: assert property (@(posedge core_clk) disable iff (rst)
    q.st == MCG_S_DONE && stk && op inside {MCG_OP_ADD, MCG_OP_SUB} && q.depth >= 4'h2
    |=> q.top == $past(q.top) + 3'h1 && q.depth == $past(q.depth) - 4'h1)
    else $error("stack pop wrong");
  zero_div_a: assert property (@(posedge core_clk) disable iff (rst)
    q.st == MCG_S_DONE && op == MCG_OP_DIV && rd_b[63:0] == 64'h0 && (!stk || q.depth >= 4'h2)
    |=> flags[`MCG_EX_ZE]) else $error("zero divide not flagged");
  load_push_a: assert property (@(posedge core_clk) disable iff (rst)
    q.st == MCG_S_DONE && stk && op == MCG_OP_LOAD && q.depth < `MCG_DEPTH_MAX
    |=> q.depth == $past(q.depth) + 4'h1) else $error("load did not push");
  // popping an empty stack is an invalid operation, not a silent read
  empty_store_a: assert property (@(posedge core_clk) disable iff (rst)
    q.st == MCG_S_DONE && stk && op == MCG_OP_STORE && q.depth == 4'h0
    |=> flags[`MCG_EX_IE]) else $error("empty stack store not flagged");
endmodule

// ===== common/mcg_defines.svh
// port addresses, field positions, reset values and timing counts
// assumes the includer compiles it once per unit; guarded anyway
`ifndef MCG_DEFINES_SVH
`define MCG_DEFINES_SVH
// host i/o port addresses
`define MCG_PORT_CMD 16'h00F8
`define MCG_PORT_OPND 16'h00FA
`define MCG_PORT_CTRL 16'h00FC
`define MCG_PORT_CLR 16'h00F0
// command word fields
`define MCG_CMD_FIX 9
// exception flag bit positions
`define MCG_EX_IE 0
`define MCG_EX_DE 1
`define MCG_EX_ZE 2
`define MCG_EX_OE 3
`define MCG_EX_UE 4
`define MCG_EX_PE 5
// control word reset: every exception masked
`define MCG_CTRL_RST 16'h003F
// stack depth limit
`define MCG_DEPTH_MAX 4'h8
// timing: clock period and execution time in ns, and the execution cycle count
`define MCG_CLK_NS 50
`define MCG_EXEC_NS 400
`define MCG_EXEC_CYC ((`MCG_EXEC_NS + `MCG_CLK_NS - 1) / `MCG_CLK_NS)
`endif

// ===== common/mcg_pkg.sv
// types shared by the coprocessor core and its helpers
// assumes nothing beyond a systemverilog compiler
package mcg_pkg;
  // operation codes, command bits [2:0]
  typedef enum logic [2:0] {
    MCG_OP_LOAD = 3'h0, MCG_OP_STORE = 3'h1, MCG_OP_ADD = 3'h2, MCG_OP_SUB = 3'h3,
    MCG_OP_MUL = 3'h4, MCG_OP_DIV = 3'h5, MCG_OP_CHS = 3'h6, MCG_OP_FCLR = 3'h7
  } mcg_op_e;
  // operand formats, command bits [5:3]
  typedef enum logic [2:0] {
    MCG_F_I16 = 3'h0, MCG_F_I32 = 3'h1, MCG_F_I64 = 3'h2, MCG_F_BCD = 3'h3,
    MCG_F_R24 = 3'h4, MCG_F_R53 = 3'h5, MCG_F_R64 = 3'h6
  } mcg_fmt_e;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    MCG_S_IDLE = 3'b001, MCG_S_EXEC = 3'b010, MCG_S_DONE = 3'b100
  } mcg_state_e;
  typedef logic [79:0] mcg_word_t;
  // core state
  typedef struct packed {
    mcg_state_e st;
    logic [3:0] cnt;
    logic [15:0] cmd;
    mcg_word_t opnd;
    mcg_word_t res;
    logic [15:0] ctrl;
    logic [2:0] top;
    logic [3:0] depth;
    logic [15:0] rdata;
    logic hold;
    logic irq;
    logic err_prev;
  } mcg_core_s;
  // register file state
  typedef struct packed {
    logic [7:0][79:0] r;
  } mcg_regs_s;
  // exception state
  typedef struct packed {
    logic [5:0] flags;
    logic err;
  } mcg_exc_s;
endpackage

// ===== logic/mcg_regs.sv
// eight 80-bit data registers, one write port, two read ports
// assumes the core computes indices for stack or fixed use
`timescale 1ns/10ps
module mcg_regs
  import mcg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire mcg_word_t wr_data,
  input wire logic [2:0] rd_a_idx,
  input wire logic [2:0] rd_b_idx,
  output mcg_word_t rd_a,
  output mcg_word_t rd_b
);
  mcg_regs_s q, d; // whole register file

  // reads straight from the flops
  assign rd_a = q.r[rd_a_idx];
  assign rd_b = q.r[rd_b_idx];

  // single write per cycle; the sequencer never needs two
  always_comb begin
    d = q;
    if (wr_en) begin
      d.r[wr_idx] = wr_data;
    end
  end

  // register the copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // a written word must be readable on the next cycle
  reg_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_en |=> q.r[$past(wr_idx)] == $past(wr_data)) else $error("register write lost");
endmodule

// ===== logic/mcg_exc.sv
// sticky exception flags, mask gating and the error output
// assumes det is meaningful only while det_v is high
`timescale 1ns/10ps
`include "mcg_defines.svh"
module mcg_exc
  import mcg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] det,
  input wire logic det_v,
  input wire logic clr,
  input wire logic [5:0] mask,
  output logic [5:0] flags,
  output logic error
);
  mcg_exc_s q, d; // flags and registered error

  assign flags = q.flags;
  assign error = q.err;

  // set wins over clear, so a fresh event is never lost
  always_comb begin
    d = q;
    if (clr) begin
      d.flags = '0;
    end
    if (det_v) begin
      d.flags = d.flags | det;
    end
    // only unmasked flags reach the error output
    d.err = |(d.flags & ~mask);
  end

  // register the copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  unmasked_err_a: assert property (@(posedge core_clk) disable iff (rst)
    det_v && |(det & ~mask) |=> error) else $error("unmasked exception without error");
  masked_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    (q.flags & ~mask) == '0 && !det_v && $stable(mask) |=> !error)
    else $error("error raised with all flags masked");
endmodule

// ===== verif/mcg_host_model.sv
// host side of the coprocessor port: i/o cycles and the wait instruction
// assumes the design takes a strobe on the rising core_clk edge
`timescale 1ns/10ps
module mcg_host_model (
  input wire logic core_clk,
  input wire logic busy,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic io_byte,
  output logic [15:0] io_wdata
);
  // bus idle at time zero
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_byte = 1'b0;
    io_wdata = 16'h0000;
  end
  // one port cycle, driven after a falling edge and held across the taking edge
  task automatic cyc(input logic [15:0] a, input logic [15:0] d, input logic wr,
                     input logic by);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = d;
    io_byte = by;
    io_wr = wr;
    io_rd = ~wr;
    @(negedge core_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_byte = 1'b0;
    // released data must not look like the last value
    io_wdata = ~d;
  endtask
  // wait instruction: stall while busy, bounded so a stuck design cannot hang
  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 64) begin
      n++;
      @(negedge core_clk);
    end
  endtask
endmodule

// ===== verif/test_math_coproc_host_glue.sv
// self-checking bench for the coprocessor core behind its host ports
// assumes mcg_core on core_clk with async rst, host model as bus master
`timescale 1ns/10ps
`include "mcg_defines.svh"
module test_math_coproc_host_glue;
  import mcg_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] io_addr, io_wdata, io_rdata;
  logic io_wr, io_rd, io_byte, busy, error, irq13;
  logic rd_taken = 1'b0; // read accepted at the last edge
  logic [15:0] exp_q[$]; // expected read words, oldest first
  logic [15:0] msk_q[$]; // bits that matter per read
  logic [15:0] a, b;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 5;
  int n;

  mcg_core dut (.core_clk(core_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_byte(io_byte), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .busy(busy), .error(error), .irq13(irq13));
  mcg_host_model host (.core_clk(core_clk), .busy(busy), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_byte(io_byte), .io_wdata(io_wdata));

  // 50 ns clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // verdict in one place
  task automatic stop_test;
    // a noted read whose answer never came counts against the run
    if (exp_q.size() != 0) begin
      n_mismatch++;
    end
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // pin levels as {busy, error, irq13}
  task automatic cmp_pins(input logic [2:0] exp);
    cmp16({13'h0000, busy, error, irq13}, {13'h0000, exp});
  endtask
  task automatic wr(input logic [15:0] adr, input logic [15:0] d);
    host.cyc(adr, d, 1'b1, 1'b0);
  endtask
  // reads note their expectation first; the watcher compares
  task automatic rd(input logic [15:0] adr, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    host.cyc(adr, 16'h0000, 1'b0, 1'b0);
  endtask
  // command word, then the wait instruction; busy must stand eight cycles
  task automatic issue(input logic [15:0] w);
    host.cyc(`MCG_PORT_CMD, w, 1'b1, 1'b0);
    host.wait_idle(n);
    cmp16(16'(n), 16'h0008);
  endtask
  // stack command: index field unused, fixed bit clear
  task automatic cmd(input mcg_op_e op, input mcg_fmt_e f);
    issue({7'h00, 3'h0, f, op});
  endtask
  // five operand words, last one least significant
  task automatic opnd(input logic [15:0] v);
    repeat (4) wr(`MCG_PORT_OPND, 16'h0000);
    wr(`MCG_PORT_OPND, v);
  endtask
  // operand words, then a push
  task automatic load(input logic [15:0] v, input mcg_fmt_e f);
    opnd(v);
    cmd(MCG_OP_LOAD, f);
  endtask

  // read data stands in the cycle after the taking edge
  always @(posedge core_clk) rd_taken <= io_rd;
  always @(negedge core_clk) begin
    if (rd_taken && exp_q.size() > 0) begin
      cmp16(io_rdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #(50 * 20000);
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    cmp_pins(3'b000);
    rd(`MCG_PORT_CMD, 16'h0000, 16'hffff);
    rd(16'h00F4, 16'h0000, 16'hffff);
    // two random values summed on the stack
    a = 16'($random(seed)) & 16'h3fff;
    b = 16'($random(seed)) & 16'h3fff;
    load(a, MCG_F_I16);
    load(b, MCG_F_I16);
    rd(`MCG_PORT_CMD, {2'b00, 3'h6, 4'h2, 7'h00}, 16'hffff);
    cmd(MCG_OP_ADD, MCG_F_I16);
    rd(`MCG_PORT_CMD, {2'b00, 3'h7, 4'h1, 7'h00}, 16'hffff);
    cmd(MCG_OP_STORE, MCG_F_I64);
    // positive sum: every word above the lowest is zero sign fill
    rd(`MCG_PORT_OPND, 16'h0000, 16'hffff);
    repeat (3) rd(`MCG_PORT_OPND, 16'h0000, 16'hffff);
    rd(`MCG_PORT_OPND, a + b, 16'hffff);
    // fixed set: reg 2 plus reg 3 lands in reg 2, stack untouched
    opnd(a);
    issue({6'h00, 1'b1, 3'h2, MCG_F_I16, MCG_OP_LOAD});
    opnd(b);
    issue({6'h00, 1'b1, 3'h3, MCG_F_I16, MCG_OP_LOAD});
    issue({6'h00, 1'b1, 3'h2, MCG_F_I16, MCG_OP_ADD});
    issue({6'h00, 1'b1, 3'h2, MCG_F_I16, MCG_OP_STORE});
    rd(`MCG_PORT_CMD, 16'h0000, 16'hffff);
    repeat (4) rd(`MCG_PORT_OPND, 16'h0000, 16'hffff);
    rd(`MCG_PORT_OPND, a + b, 16'hffff);
    // every operand format through a push, a pop and a read-back
    for (int f = 0; f < 7; f++) begin
      a = 16'($random(seed));
      load(a, mcg_fmt_e'(3'(f)));
      cmd(MCG_OP_STORE, mcg_fmt_e'(3'(f)));
      // only the 16-bit integer widens with its sign; the rest keep zero above
      repeat (4) rd(`MCG_PORT_OPND, (f == 0 && a[15]) ? 16'hffff : 16'h0000, 16'hffff);
      rd(`MCG_PORT_OPND, a, 16'hffff);
    end
    // a command while executing is dropped, so busy ends with the first one
    host.cyc(`MCG_PORT_CMD, {10'h000, MCG_F_I16, MCG_OP_FCLR}, 1'b1, 1'b0);
    host.cyc(`MCG_PORT_CMD, {10'h000, MCG_F_I16, MCG_OP_LOAD}, 1'b1, 1'b0);
    host.wait_idle(n);
    cmp16(16'(n), 16'h0006);
    rd(`MCG_PORT_CMD, 16'h0000, 16'hffff);
    // popping an empty stack flags an invalid operation, masked here
    cmd(MCG_OP_STORE, MCG_F_I16);
    rd(`MCG_PORT_CMD, 16'h0001, 16'hffff);
    // unmasked divide by zero: error, irq and held busy
    cmd(MCG_OP_FCLR, MCG_F_I16);
    wr(`MCG_PORT_CTRL, 16'h0000);
    load(16'h0000, MCG_F_I16);
    load(16'h0000, MCG_F_I16);
    cmd(MCG_OP_DIV, MCG_F_I16);
    repeat (2) @(negedge core_clk);
    cmp_pins(3'b111);
    // status while held: busy, hold, top 7, depth 1, error, zero-divide flag
    rd(`MCG_PORT_CMD, {2'b11, 3'h7, 4'h1, 1'b1, 6'h04}, 16'hffff);
    // clear needs a byte cycle with a zero low byte
    host.cyc(`MCG_PORT_CLR, 16'h0001, 1'b1, 1'b1);
    host.cyc(`MCG_PORT_CLR, 16'h0000, 1'b1, 1'b0);
    cmp_pins(3'b111);
    host.cyc(`MCG_PORT_CLR, 16'hff00, 1'b1, 1'b1);
    cmp_pins(3'b010);
    // masked: flags may set but error must stay low
    wr(`MCG_PORT_CTRL, 16'h003f);
    repeat (3) @(negedge core_clk);
    cmp_pins(3'b000);
    cmd(MCG_OP_FCLR, MCG_F_I16);
    load(16'h0000, MCG_F_I16);
    load(16'h0000, MCG_F_I16);
    cmd(MCG_OP_DIV, MCG_F_I16);
    repeat (2) @(negedge core_clk);
    cmp_pins(3'b000);
    // unmasking a pending flag raises error, then the hold
    wr(`MCG_PORT_CTRL, 16'h0000);
    repeat (3) @(negedge core_clk);
    cmp_pins(3'b111);
    // second reset in mid-run drops the hold and the request
    rst = 1'b1;
    @(negedge core_clk);
    cmp_pins(3'b000);
    rst = 1'b0;
    rd(`MCG_PORT_CMD, 16'h0000, 16'hffff);
    repeat (4) @(negedge core_clk);
    stop_test();
  end
endmodule
